// ### shared/cmic_pkg.sv
// Register map, fields and timing constants of the CAN mode and interrupt control block
package cmic_pkg;
  localparam logic [7:0] CMIC_CTL0  = 8'h00;
  localparam logic [7:0] CMIC_CTL1  = 8'h04;
  localparam logic [7:0] CMIC_RFLG  = 8'h08;
  localparam logic [7:0] CMIC_RIER  = 8'h0C;
  localparam logic [7:0] CMIC_TFLG  = 8'h10;
  localparam logic [7:0] CMIC_TIER  = 8'h14;
  localparam logic [7:0] CMIC_TARQ  = 8'h18;
  localparam logic [7:0] CMIC_TAAK  = 8'h1C;
  localparam logic [7:0] CMIC_TBSEL = 8'h20;
  localparam logic [7:0] CMIC_BTR0  = 8'h24;
  localparam logic [7:0] CMIC_BTR1  = 8'h28;
  localparam logic [7:0] CMIC_IDAC  = 8'h2C;
  localparam logic [7:0] CMIC_IDAR  = 8'h30;
  localparam logic [7:0] CMIC_IDMR  = 8'h34;
  // control_reg0 fields
  localparam int C0_INIT = 0;
  localparam int C0_SLPR = 1;
  localparam int C0_WAKEUP_ENABLE = 2;
  localparam int C0_CSWI = 3;
  // control_reg1 fields
  localparam int C1_INAK = 0;
  localparam int C1_SLAK = 1;
  localparam int C1_WAKEUP_FILTER_MODE = 2;
  localparam int C1_ENA  = 7;
  // rx_flag_reg and rx_irq_enable_reg fields
  localparam int RF_RXF  = 0;
  localparam int RF_OVR  = 1;
  localparam int RF_TST  = 2;
  localparam int RF_RST  = 4;
  localparam int RF_CSC  = 6;
  localparam int RF_WUP  = 7;
  localparam logic [2:0] TXE_RESET = 3'h7;
  localparam logic [1:0] ERR_OK    = 2'h0;
  // Timing
  localparam int BUS_SYNC_CYC  = 2;
  localparam int CAN_SYNC_CYC  = 3;
  localparam int INIT_SYNC_CYC = BUS_SYNC_CYC + CAN_SYNC_CYC;
  localparam int RECOVER_NS    = 160;
  localparam int CLK_NS        = 10;
  localparam int RECOVER_CYC   = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECESSIVE_BITS = 11;
  localparam int WUP_FILTER_CYC = 8;
  typedef enum logic [1:0] {CMIC_RUN, CMIC_DOWN, CMIC_RECOVER} cmic_pwr_t;
endpackage

// ### core/cmic_ctrl.sv
// CAN controller mode, power-down, wake-up and interrupt control with Wishbone registers
//
// Operation
// - Init entry aborts traffic at once and forces transmit pin recessive.
// - Init halts the engine; registers stay readable and writable.
// - Init returns control, flag, enable, abort and select registers to defaults. The code returns control register 0 only; control register 1 keeps its value.
// - Bit timing and acceptance registers are writable only in init mode.
// - Init request crosses to engine through handshake: two plus three cycles.
// - Init ack sets only when all parts reached init; software waits.
// - Clearing init request is ignored until request and ack both set.
// - Power-down when CPU stops, or waits with stop-in-wait set.
// - Power-down entry stops traffic at once, transmit pin recessive.
// - Power-down blocks register access; recovery delay if not slept before.
// - Bus activity wakes from sleep when enabled; optional glitch filter.
// - Four maskable interrupts: wake-up, error, receive, transmit per buffer.
// - Each transmit empty flag set while its buffer is unscheduled.
// - Receive full flag set when a good message enters foreground buffer.
// - Wake-up flag set on bus activity in sleep, only when enabled.
// - Error interrupt on overrun or error state change; states reported. The code flags only changes into a state other than ERR_OK.
// - Interrupt pends while flag set; write one clears unless cause holds.
// - Wake from power-down only if slept before, wake-up and irq enabled.
// - Sleep active exactly when sleep request and sleep ack both set.
// - After wake, wait eleven recessive bits before joining bus.
//
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module cmic_ctrl
  import cmic_pkg::*;
#(
  parameter int RECOVER_CYCLES = RECOVER_CYC,
  parameter int FILTER_CYCLES  = WUP_FILTER_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // CPU power state
  input  wire logic        cpu_stop_i,
  input  wire logic        cpu_wait_i,
  // CAN pins and protocol engine
  input  wire logic        bus_rx_pin_i,
  input  wire logic        engine_tx_i,
  input  wire logic        bit_tick_i,
  input  wire logic        engine_idle_i,
  input  wire logic        rx_msg_done_i,
  input  wire logic        rx_overrun_i,
  input  wire logic [1:0]  tx_error_state_i,
  input  wire logic [1:0]  rx_error_state_i,
  input  wire logic [2:0]  tx_sent_i,
  input  wire logic [2:0]  tx_abort_ack_i,
  output logic             bus_tx_pin_o,
  output logic             bus_rx_o,
  output logic             engine_run_o,
  output logic             engine_abort_o,
  output logic [2:0]       tx_sched_o,
  output logic [2:0]       tx_abort_request_o,
  // Configuration
  output logic [7:0]       bit_timing0_o,
  output logic [7:0]       bit_timing1_o,
  output logic [7:0]       id_accept_control_o,
  output logic [31:0]      id_accept_o,
  output logic [31:0]      id_mask_o,
  // Status and interrupts
  output logic             power_down_o,
  output logic             wakeup_irq_o,
  output logic             error_irq_o,
  output logic             rx_irq_o,
  output logic             tx_irq_o
);

  logic [3:0]  control_reg0;
  logic [7:0]  control_reg1;
  logic        init_ack_reg;
  logic        sleep_ack_reg;
  logic [INIT_SYNC_CYC-1:0] init_sync_reg;
  logic        rx_full_flag, overrun_flag, status_change_flag, wakeup_irq_flag;
  logic [1:0]  tx_error_state, rx_error_state;
  logic [7:0]  rx_irq_enable_reg;
  logic [2:0]  tx_empty_flags, tx_empty_irq_enables;
  logic [2:0]  tx_abort_request_reg, tx_buffer_select_reg;
  logic [7:0]  bit_timing_reg0, bit_timing_reg1, id_accept_control_reg;
  logic [31:0] id_accept_regs, id_mask_regs;
  logic        ack_reg;
  logic        wr, init_mode, sleep_active, pd, slept_before_pd;
  logic        rx_seen, wake_evt, bus_on_reg;
  logic [7:0]  filt_cnt;
  logic [3:0]  rec_cnt;
  logic [15:0] recov_cnt;
  logic        wr_init_clr;
  cmic_pwr_t   pwr_state;

  function automatic logic hit(input logic [7:0] off);
    return adr_i == off;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel_i[i]) begin
        r[8*i +: 8] = dat_i[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Bus write strobe, blocked in power-down
  assign wr           = cyc_i & stb_i & we_i & ack_reg & ~pd & sel_i[0];
  assign init_mode    = control_reg0[C0_INIT] & init_ack_reg;
  assign sleep_active = control_reg0[C0_SLPR] & sleep_ack_reg;
  assign pd           = cpu_stop_i | (cpu_wait_i & control_reg0[C0_CSWI]);
  assign power_down_o = pd;
  assign ack_o        = ack_reg;
  assign wr_init_clr  = wr & hit(CMIC_CTL0) & ~dat_i[C0_INIT];

  // Wishbone ack and read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_o   <= 32'h0;
    end else begin
      ack_reg <= cyc_i & stb_i & ~ack_reg;
      if (cyc_i & stb_i & ~ack_reg) begin
        dat_o <= 32'h0;
        if (!pd) begin
          unique case (adr_i)
            CMIC_CTL0:  dat_o <= {28'h0, control_reg0};
            CMIC_CTL1:  dat_o <= {24'h0, control_reg1[7:3], control_reg1[C1_WAKEUP_FILTER_MODE],
                                  sleep_ack_reg, init_ack_reg};
            CMIC_RFLG:  dat_o <= {24'h0, wakeup_irq_flag, status_change_flag,
                                  rx_error_state, tx_error_state, overrun_flag, rx_full_flag};
            CMIC_RIER:  dat_o <= {24'h0, rx_irq_enable_reg};
            CMIC_TFLG:  dat_o <= {29'h0, tx_empty_flags};
            CMIC_TIER:  dat_o <= {29'h0, tx_empty_irq_enables};
            CMIC_TARQ:  dat_o <= {29'h0, tx_abort_request_reg};
            CMIC_TAAK:  dat_o <= {29'h0, tx_abort_ack_i};
            CMIC_TBSEL: dat_o <= {29'h0, tx_buffer_select_reg};
            CMIC_BTR0:  dat_o <= {24'h0, bit_timing_reg0};
            CMIC_BTR1:  dat_o <= {24'h0, bit_timing_reg1};
            CMIC_IDAC:  dat_o <= {24'h0, id_accept_control_reg};
            CMIC_IDAR:  dat_o <= id_accept_regs;
            CMIC_IDMR:  dat_o <= id_mask_regs;
            default:    dat_o <= 32'h0;
          endcase
        end
      end
    end
  end

  // Control register 0 and 1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control_reg0            <= 4'h1;
      control_reg1            <= 8'h0;
    end else begin
      if (wr && hit(CMIC_CTL0)) begin
        if (dat_i[C0_INIT] || (control_reg0[C0_INIT] && init_ack_reg)) begin
          control_reg0[C0_INIT] <= dat_i[C0_INIT];
        end
        if (dat_i[C0_SLPR] || sleep_active) begin
          control_reg0[C0_SLPR] <= dat_i[C0_SLPR];
        end
        control_reg0[C0_WAKEUP_ENABLE] <= dat_i[C0_WAKEUP_ENABLE];
        control_reg0[C0_CSWI] <= dat_i[C0_CSWI];
      end
      if (init_mode && !wr_init_clr) begin
        control_reg0[3:1] <= 3'h0;
      end else if (wake_evt) begin
        control_reg0[C0_SLPR] <= 1'b0;
      end
      if (wr && hit(CMIC_CTL1)) begin
        control_reg1[C1_ENA]  <= dat_i[C1_ENA];
        control_reg1[C1_WAKEUP_FILTER_MODE] <= dat_i[C1_WAKEUP_FILTER_MODE];
      end
    end
  end

  // Init request handshake through bus and CAN stages
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_sync_reg <= '0;
      init_ack_reg  <= 1'b0;
    end else begin
      init_sync_reg <= {init_sync_reg[INIT_SYNC_CYC-2:0], control_reg0[C0_INIT]};
      if (control_reg0[C0_INIT] && init_sync_reg[INIT_SYNC_CYC-1]) begin
        init_ack_reg <= 1'b1;
      end else if (!control_reg0[C0_INIT] && !init_sync_reg[INIT_SYNC_CYC-1]) begin
        init_ack_reg <= 1'b0;
      end
    end
  end

  // Sleep acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_ack_reg <= 1'b0;
    end else if (control_reg0[C0_SLPR] && engine_idle_i && !wake_evt) begin
      sleep_ack_reg <= 1'b1;
    end else if (!control_reg0[C0_SLPR] || wake_evt) begin
      sleep_ack_reg <= 1'b0;
    end
  end

  // Wake-up detector with optional low-pass filter
  assign rx_seen  = control_reg1[C1_WAKEUP_FILTER_MODE] ? (filt_cnt == 8'(FILTER_CYCLES)) : ~bus_rx_pin_i;
  assign wake_evt = sleep_active & control_reg0[C0_WAKEUP_ENABLE] & rx_seen;
  assign bus_rx_o = sleep_active & ~control_reg0[C0_WAKEUP_ENABLE] ? 1'b1 : bus_rx_pin_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_cnt <= 8'h0;
    end else if (!sleep_active || bus_rx_pin_i) begin
      filt_cnt <= 8'h0;
    end else if (filt_cnt != 8'(FILTER_CYCLES)) begin
      filt_cnt <= filt_cnt + 8'h1;
    end
  end

  // Bus integration: eleven recessive bits after wake or start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rec_cnt    <= 4'h0;
      bus_on_reg <= 1'b0;
    end else if (sleep_active || init_mode || pd || wake_evt) begin
      rec_cnt    <= 4'h0;
      bus_on_reg <= 1'b0;
    end else if (bit_tick_i && !bus_on_reg) begin
      if (!bus_rx_pin_i) begin
        rec_cnt <= 4'h0;
      end else if (rec_cnt == 4'(RECESSIVE_BITS - 1)) begin
        bus_on_reg <= 1'b1;
      end else begin
        rec_cnt <= rec_cnt + 4'h1;
      end
    end
  end

  // Power-down and recovery
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_state       <= CMIC_RUN;
      slept_before_pd <= 1'b0;
      recov_cnt       <= 16'h0;
    end else begin
      unique case (pwr_state)
        CMIC_RUN: if (pd) begin
          pwr_state       <= CMIC_DOWN;
          slept_before_pd <= sleep_active;
        end
        CMIC_DOWN: if (!pd) begin
          recov_cnt <= 16'h0;
          pwr_state <= slept_before_pd ? CMIC_RUN : CMIC_RECOVER;
        end
        CMIC_RECOVER: if (recov_cnt == 16'(RECOVER_CYCLES - 1)) begin
          pwr_state <= CMIC_RUN;
        end else begin
          recov_cnt <= recov_cnt + 16'h1;
        end
        default: pwr_state <= CMIC_RUN;
      endcase
    end
  end

  // Engine control and transmit pin
  assign engine_abort_o = control_reg0[C0_INIT] | pd;
  assign engine_run_o   = control_reg1[C1_ENA] & ~control_reg0[C0_INIT] & ~init_ack_reg
                          & ~sleep_active & ~pd & (pwr_state == CMIC_RUN) & bus_on_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_tx_pin_o <= 1'b1;
    end else begin
      bus_tx_pin_o <= engine_abort_o | ~engine_run_o ? 1'b1 : engine_tx_i;
    end
  end

  // Receive flags and enables
  always_ff @(posedge clk_i) begin
    if (rst_i || init_mode) begin
      rx_full_flag       <= 1'b0;
      overrun_flag       <= 1'b0;
      status_change_flag <= 1'b0;
      wakeup_irq_flag    <= 1'b0;
      tx_error_state     <= ERR_OK;
      rx_error_state     <= ERR_OK;
      rx_irq_enable_reg  <= 8'h0;
    end else begin
      if (wr && hit(CMIC_RFLG)) begin
        if (dat_i[RF_RXF]) rx_full_flag <= 1'b0;
        if (dat_i[RF_OVR]) overrun_flag <= 1'b0;
        if (dat_i[RF_CSC]) status_change_flag <= 1'b0;
        if (dat_i[RF_WUP]) wakeup_irq_flag <= 1'b0;
      end
      if (rx_msg_done_i && !sleep_active) rx_full_flag <= 1'b1;
      if (rx_overrun_i) overrun_flag <= 1'b1;
      tx_error_state <= tx_error_state_i;
      rx_error_state <= rx_error_state_i;
      if ((tx_error_state_i != tx_error_state && tx_error_state_i != ERR_OK) ||
          (rx_error_state_i != rx_error_state && rx_error_state_i != ERR_OK)) begin
        status_change_flag <= 1'b1;
      end
      if (wake_evt) wakeup_irq_flag <= 1'b1;
      if (wr && hit(CMIC_RIER)) rx_irq_enable_reg <= dat_i[7:0];
    end
  end

  // Transmit flags, enables, abort and select
  always_ff @(posedge clk_i) begin
    if (rst_i || init_mode) begin
      tx_empty_flags       <= TXE_RESET;
      tx_empty_irq_enables <= 3'h0;
      tx_abort_request_reg <= 3'h0;
      tx_buffer_select_reg <= 3'h0;
      tx_sched_o           <= 3'h0;
    end else begin
      tx_sched_o <= 3'h0;
      if (wr && hit(CMIC_TFLG)) begin
        tx_empty_flags <= tx_empty_flags & ~dat_i[2:0] | tx_sent_i;
        tx_sched_o     <= dat_i[2:0] & tx_empty_flags & ~tx_sent_i;
      end else begin
        tx_empty_flags <= tx_empty_flags | tx_sent_i;
      end
      if (wr && hit(CMIC_TIER)) tx_empty_irq_enables <= dat_i[2:0];
      if (wr && hit(CMIC_TARQ)) begin
        tx_abort_request_reg <= dat_i[2:0] & ~tx_empty_flags;
      end else begin
        tx_abort_request_reg <= tx_abort_request_reg & ~tx_empty_flags;
      end
      if (wr && hit(CMIC_TBSEL)) tx_buffer_select_reg <= dat_i[2:0];
    end
  end
  assign tx_abort_request_o = tx_abort_request_reg;

  // Configuration registers, writable in init mode only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bit_timing_reg0       <= 8'h0;
      bit_timing_reg1       <= 8'h0;
      id_accept_control_reg <= 8'h0;
      id_accept_regs        <= 32'h0;
      id_mask_regs          <= 32'h0;
    end else if (wr && init_mode) begin
      if (hit(CMIC_BTR0)) bit_timing_reg0 <= dat_i[7:0];
      if (hit(CMIC_BTR1)) bit_timing_reg1 <= dat_i[7:0];
      if (hit(CMIC_IDAC)) id_accept_control_reg <= dat_i[7:0];
      if (hit(CMIC_IDAR)) id_accept_regs <= merge(id_accept_regs);
      if (hit(CMIC_IDMR)) id_mask_regs <= merge(id_mask_regs);
    end
  end
  assign bit_timing0_o       = bit_timing_reg0;
  assign bit_timing1_o       = bit_timing_reg1;
  assign id_accept_control_o = id_accept_control_reg;
  assign id_accept_o         = id_accept_regs;
  assign id_mask_o           = id_mask_regs;

  // Interrupt outputs
  assign wakeup_irq_o = wakeup_irq_flag & rx_irq_enable_reg[RF_WUP]
                        & (pwr_state != CMIC_DOWN | slept_before_pd);
  assign error_irq_o  = (status_change_flag & rx_irq_enable_reg[RF_CSC]) |
                        (overrun_flag & rx_irq_enable_reg[RF_OVR]);
  assign rx_irq_o     = rx_full_flag & rx_irq_enable_reg[RF_RXF];
  assign tx_irq_o     = |(tx_empty_flags & tx_empty_irq_enables);

  // Checks
  property p_init_ack_delay;
    @(posedge clk_i) disable iff (rst_i)
      $rose(control_reg0[C0_INIT]) |-> !init_ack_reg [*6] ##1 init_ack_reg;
  endproperty
  a_init_ack_delay: assert property (p_init_ack_delay) else $error("init ack timing");
  property p_ack_needs_req;
    @(posedge clk_i) disable iff (rst_i) $rose(init_ack_reg) |-> control_reg0[C0_INIT];
  endproperty
  a_ack_needs_req: assert property (p_ack_needs_req) else $error("ack without request");
  property p_init_hold;
    @(posedge clk_i) disable iff (rst_i)
      control_reg0[C0_INIT] && !init_ack_reg |=> control_reg0[C0_INIT];
  endproperty
  a_init_hold: assert property (p_init_hold) else $error("init request cleared early");
  property p_tx_recessive;
    @(posedge clk_i) disable iff (rst_i) $past(engine_abort_o) |-> bus_tx_pin_o;
  endproperty
  a_tx_recessive: assert property (p_tx_recessive) else $error("tx pin not recessive");
  property p_pd_halt;
    @(posedge clk_i) disable iff (rst_i) pd |-> !engine_run_o && engine_abort_o;
  endproperty
  a_pd_halt: assert property (p_pd_halt) else $error("engine runs in power-down");
  property p_cfg_locked;
    @(posedge clk_i) disable iff (rst_i) !init_mode |=> $stable(bit_timing_reg0);
  endproperty
  a_cfg_locked: assert property (p_cfg_locked) else $error("timing written outside init");
  property p_wake_flag;
    @(posedge clk_i) disable iff (rst_i)
      $rose(wakeup_irq_flag) |-> $past(sleep_active && control_reg0[C0_WAKEUP_ENABLE]);
  endproperty
  a_wake_flag: assert property (p_wake_flag) else $error("wake flag without sleep");
  property p_sleep_ack;
    @(posedge clk_i) disable iff (rst_i)
      sleep_ack_reg |-> $past(control_reg0[C0_SLPR] && !wake_evt);
  endproperty
  a_sleep_ack: assert property (p_sleep_ack) else $error("sleep ack without request");
  property p_rx_set;
    @(posedge clk_i) disable iff (rst_i || init_mode)
      rx_msg_done_i && !sleep_active |=> rx_full_flag;
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("rx full lost");
endmodule

// ### tb/cmic_can_node.sv
// CAN bus partner: recessive idle, dominant bursts, bit ticks
`timescale 1ns/1ps
module cmic_can_node (
  // Clock
  input  wire logic clk_i,
  // Bus side
  output logic      rx_o,
  output logic      tick_o
);
  int cnt = 0;
  initial rx_o = 1'b1;
  initial tick_o = 1'b0;
  always @(posedge clk_i) begin
    cnt <= (cnt + 1) % 4;
    tick_o <= (cnt == 3);
  end
  task automatic dominant(input int n);
    @(posedge clk_i);
    rx_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    rx_o <= 1'b1;
  endtask
endmodule

// ### tb/can_mode_interrupt_control_tb.sv
// Self-checking bench for the CAN mode and interrupt control block
`timescale 1ns/1ps
module can_mode_interrupt_control_tb;
  import cmic_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i, cyc_i, stb_i, we_i, cpu_stop_i, cpu_wait_i, engine_tx_i;
  logic        engine_idle_i, rx_msg_done_i, rx_overrun_i, ack_o, bus_tx_pin_o;
  logic        engine_abort_o, power_down_o, wakeup_irq_o, error_irq_o, rx_irq_o, tx_irq_o;
  logic        bus_rx_pin_i, bit_tick_i, engine_run_o;
  logic [1:0]  tx_error_state_i, rx_error_state_i;
  logic [2:0]  tx_sent_i, tx_abort_ack_i;
  logic [3:0]  sel_i;
  logic [7:0]  adr_i, bit_timing0_o;
  logic [31:0] dat_i, dat_o, q, v;
  logic [31:0] sh [logic [7:0]];
  int          error_cnt = 0;
  int          tests_run = 0;
  int          seed = 32'hbec7;
  always #5 clk_i = ~clk_i;
  cmic_can_node u_node (.clk_i, .rx_o(bus_rx_pin_i), .tick_o(bit_tick_i));
  cmic_ctrl #(.RECOVER_CYCLES(4), .FILTER_CYCLES(2)) u_dut (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .cpu_stop_i, .cpu_wait_i, .bus_rx_pin_i, .engine_tx_i, .bit_tick_i, .engine_idle_i,
    .rx_msg_done_i, .rx_overrun_i, .tx_error_state_i, .rx_error_state_i, .tx_sent_i,
    .tx_abort_ack_i, .bus_tx_pin_o, .bus_rx_o(), .engine_run_o, .engine_abort_o,
    .tx_sched_o(), .tx_abort_request_o(), .bit_timing0_o, .bit_timing1_o(),
    .id_accept_control_o(), .id_accept_o(), .id_mask_o(), .power_down_o,
    .wakeup_irq_o, .error_irq_o, .rx_irq_o, .tx_irq_o);
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 20) error_cnt++;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, q);
  endtask
  task rc(input logic [7:0] a);
    wb(1'b0, a, 32'h0, q);
    chk(q, sh[a]);
  endtask
  task poll(input logic [7:0] a, input int b, input logic val);
    int n;
    n = 0;
    do begin
      wb(1'b0, a, 32'h0, q);
      n++;
    end while (q[b] !== val && n < 30);
    chk({31'h0, q[b]}, {31'h0, val});
  endtask
  task conclude;
    $display("counts: %0d compares, %0d mismatches", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    conclude;
  end
  initial begin
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, adr_i, dat_i, cpu_stop_i, cpu_wait_i} = '0;
    {engine_tx_i, engine_idle_i, rx_msg_done_i, rx_overrun_i} = 4'hC;
    {tx_error_state_i, rx_error_state_i, tx_sent_i, tx_abort_ack_i} = 10'h0;
    sel_i = 4'hF;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({30'h0, bus_tx_pin_o, engine_abort_o}, 32'h3);
    poll(CMIC_CTL1, C1_INAK, 1'b1);
    sh[CMIC_CTL0] = 32'h1;
    rc(CMIC_CTL0);
    sh[CMIC_TFLG] = 32'h7;
    rc(CMIC_TFLG);
    $display("test reset done");
    wr(CMIC_CTL1, 32'h80);
    v = $random(seed) & 32'hFF;
    wr(CMIC_BTR0, v);
    sh[CMIC_BTR0] = v;
    rc(CMIC_BTR0);
    chk({24'h0, bit_timing0_o}, v);
    wr(CMIC_CTL0, 32'h0);
    poll(CMIC_CTL1, C1_INAK, 1'b0);
    wr(CMIC_BTR0, ~v & 32'hFF);
    rc(CMIC_BTR0);
    $display("test config done");
    wr(CMIC_RIER, 32'hC3);
    rx_msg_done_i <= 1'b1;
    rx_overrun_i <= 1'b1;
    rx_error_state_i <= 2'h2;
    @(posedge clk_i);
    rx_msg_done_i <= 1'b0;
    rx_overrun_i <= 1'b0;
    sh[CMIC_RFLG] = 32'h63;
    rc(CMIC_RFLG);
    chk({30'h0, rx_irq_o, error_irq_o}, 32'h3);
    wr(CMIC_RFLG, 32'h43);
    sh[CMIC_RFLG] = 32'h20;
    rc(CMIC_RFLG);
    chk({30'h0, rx_irq_o, error_irq_o}, 32'h0);
    wr(CMIC_TIER, 32'h7);
    @(negedge clk_i);
    chk({31'h0, tx_irq_o}, 32'h1);
    wr(CMIC_TFLG, 32'h1);
    sh[CMIC_TFLG] = 32'h6;
    rc(CMIC_TFLG);
    tx_sent_i <= 3'h1;
    @(posedge clk_i);
    tx_sent_i <= 3'h0;
    sh[CMIC_TFLG] = 32'h7;
    rc(CMIC_TFLG);
    $display("test flags done");
    wr(CMIC_RIER, 32'h80);
    wr(CMIC_CTL0, 32'h6);
    poll(CMIC_CTL1, C1_SLAK, 1'b1);
    u_node.dominant(4);
    poll(CMIC_RFLG, RF_WUP, 1'b1);
    chk({31'h0, wakeup_irq_o}, 32'h1);
    poll(CMIC_CTL1, C1_SLAK, 1'b0);
    wr(CMIC_RFLG, 32'h80);
    poll(CMIC_RFLG, RF_WUP, 1'b0);
    wr(CMIC_CTL0, 32'h2);
    poll(CMIC_CTL1, C1_SLAK, 1'b1);
    u_node.dominant(4);
    poll(CMIC_RFLG, RF_WUP, 1'b0);
    poll(CMIC_CTL1, C1_SLAK, 1'b1);
    wr(CMIC_CTL0, 32'h0);
    poll(CMIC_CTL1, C1_SLAK, 1'b0);
    $display("test wakeup done");
    cpu_wait_i <= 1'b1;
    engine_tx_i <= 1'($random(seed));
    @(negedge clk_i);
    chk({31'h0, power_down_o}, 32'h0);
    engine_tx_i <= 1'b0;
    wr(CMIC_CTL0, 32'h8);
    repeat (2) @(negedge clk_i);
    chk({30'h0, power_down_o, bus_tx_pin_o}, 32'h3);
    wb(1'b0, CMIC_CTL0, 32'h0, q);
    chk(q, 32'h0);
    cpu_wait_i <= 1'b0;
    cpu_stop_i <= 1'b1;
    @(negedge clk_i);
    chk({31'h0, power_down_o}, 32'h1);
    cpu_stop_i <= 1'b0;
    engine_tx_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    chk({31'h0, engine_run_o}, 32'h0);
    repeat (100) @(negedge clk_i);
    chk({31'h0, engine_run_o}, 32'h1);
    engine_tx_i <= 1'b0;
    repeat (2) @(negedge clk_i);
    chk({31'h0, bus_tx_pin_o}, 32'h0);
    engine_tx_i <= 1'b1;
    $display("test power-down done");
    wr(CMIC_CTL0, 32'h1);
    wb(1'b0, CMIC_CTL1, 32'h0, q);
    chk({31'h0, q[C1_INAK]}, 32'h0);
    wr(CMIC_CTL0, 32'h0);
    sh[CMIC_CTL0] = 32'h1;
    rc(CMIC_CTL0);
    poll(CMIC_CTL1, C1_INAK, 1'b1);
    sh[CMIC_RIER] = 32'h0;
    sh[CMIC_TIER] = 32'h0;
    rc(CMIC_RIER);
    rc(CMIC_TIER);
    $display("test reinit done");
    conclude;
  end
endmodule
